// ==== rcc_consts.vh ====
// Constants for the radio coexistence control block
`ifndef RCC_CONSTS_VH
`define RCC_CONSTS_VH

// ****************************************************************
// Register offsets
// ****************************************************************
`define RCC_ADDR_EXTEND 4'h0
`define RCC_ADDR_COEXT 4'h1
`define RCC_ADDR_FLAGS 4'h2
`define RCC_ADDR_STATUS 4'h3

// ****************************************************************
// Control register fields
// ****************************************************************
`define RCC_F_SRC_LO 0
`define RCC_F_IDIS 2
`define RCC_F_FORCE 3
`define RCC_F_IE 4
`define RCC_F_COEXSEL 5
`define RCC_F_DIRSW 6
`define RCC_F_DIRVAL 7
`define RCC_F_DENY_LO 8
`define RCC_F_QSRC 11
`define RCC_F_QSOC 12
`define RCC_F_QRF 13
`define RCC_F_WDLY_LO 16
`define RCC_COEXT_RESET 32'h0000_0000
`define RCC_COEXT_MASK 32'h003f_3fff

// ****************************************************************
// Codes and timing
// ****************************************************************
`define RCC_SRC_MODE 2'h0
`define RCC_SRC_SEQLL 2'h1
`define RCC_SRC_CLKREQ 2'h2
`define RCC_CLK_MHZ 250
`define RCC_US_CYCLES (`RCC_CLK_MHZ * 1)

`endif

// ==== rcc_coexist_control.v ====
// Radio coexistence request, direction, priority and extension logic
//
// Local design decisions: the register addresses and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
`include "rcc_consts.vh"

module rcc_coexist_control #(
  parameter DENY_PINS = 5,
  parameter US_CYCLES = `RCC_US_CYCLES
) (
  input wire clk,
  input wire nrst,
  input wire [3:0] regAddr,
  input wire [31:0] regWdata,
  input wire regWrite,
  input wire regRead,
  output reg [31:0] regRdata,
  input wire seqRequest,
  input wire seqDirection,
  input wire seqPriority,
  input wire seqBusy,
  input wire seqWarmDownStart,
  input wire llRequest,
  input wire llDirection,
  input wire [1:0] llPriority,
  input wire bleClockRequest,
  input wire lpcEnabled,
  input wire xoEnable,
  input wire lowPowerRequest,
  input wire refClk32k,
  input wire [DENY_PINS-1:0] denyPins,
  output reg [7:0] modeCtrlOutputMux,
  output reg radioRequestOut,
  output reg radioDirectionOut,
  output reg [1:0] radioPriorityOut,
  output reg radioStop,
  output reg quietSystemReq,
  output reg quietRadioReq,
  output reg requestIrq
);

  // ****************************************************************
  // Registers
  // ****************************************************************
  reg [7:0] extendUs_reg;
  reg [31:0] coext_reg;
  reg assertedFlag_reg;
  reg [7:0] extCount_reg;
  reg [7:0] extCount_next;
  reg [8:0] usTick_reg;
  reg [5:0] wakeCount_reg;
  reg wakeReq_reg;
  reg xoSeen_reg;
  reg [DENY_PINS-1:0] denySync1_reg;
  reg [DENY_PINS-1:0] denySync2_reg;
  reg [2:0] refSync_reg;
  reg reqNext;
  reg prevReq_reg;
  wire [1:0] srcSel;
  wire idleTrack;
  wire [2:0] denySel;
  wire [5:0] wakeDelay;
  wire usTick;
  wire refEdge;
  wire extActive;
  wire coexReq;
  wire coexDir;
  wire [1:0] coexPri;
  wire denyLevel;
  wire modeReq;

  assign srcSel = coext_reg[`RCC_F_SRC_LO+1:`RCC_F_SRC_LO];
  assign idleTrack = coext_reg[`RCC_F_IDIS];
  assign denySel = coext_reg[`RCC_F_DENY_LO+2:`RCC_F_DENY_LO];
  assign wakeDelay = coext_reg[`RCC_F_WDLY_LO+5:`RCC_F_WDLY_LO];

  // ****************************************************************
  // Register port
  // ****************************************************************
  // Writes, including clearing the extension by writing zero
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      extendUs_reg <= 8'h00;
      coext_reg <= `RCC_COEXT_RESET;
    end else if (regWrite) begin
      if (regAddr == `RCC_ADDR_EXTEND) begin
        extendUs_reg <= regWdata[7:0];
      end
      if (regAddr == `RCC_ADDR_COEXT) begin
        coext_reg <= regWdata & `RCC_COEXT_MASK;
      end
    end
  end

  // Read data one cycle after the strobe; unmapped reads zero
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      regRdata <= 32'h0000_0000;
    end else if (regRead) begin
      case (regAddr)
        `RCC_ADDR_EXTEND: regRdata <= {24'h000000, extendUs_reg};
        `RCC_ADDR_COEXT: regRdata <= coext_reg;
        `RCC_ADDR_FLAGS: regRdata <= {31'h00000000, assertedFlag_reg};
        `RCC_ADDR_STATUS: regRdata <= {16'h0000, extCount_reg, 3'h0, extActive,
          radioRequestOut, radioDirectionOut, radioPriorityOut};
        default: regRdata <= 32'h0000_0000;
      endcase
    end else begin
      regRdata <= 32'h0000_0000;
    end
  end

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  // Deny pins and the 32 kHz reference come from outside this clock
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      denySync1_reg <= {DENY_PINS{1'b0}};
      denySync2_reg <= {DENY_PINS{1'b0}};
      refSync_reg <= 3'h0;
    end else begin
      denySync1_reg <= denyPins;
      denySync2_reg <= denySync1_reg;
      refSync_reg <= {refSync_reg[1:0], refClk32k};
    end
  end

  assign refEdge = refSync_reg[1] & ~refSync_reg[2];
  // Code 0 disables; codes 1..5 pick a pin
  assign denyLevel = (denySel != 3'h0) && (denySel <= DENY_PINS) ?
    denySync2_reg[denySel - 3'h1] : 1'b0;

  // ****************************************************************
  // Request extension timer
  // ****************************************************************
  // Microsecond tick free-runs off the radio clock
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      usTick_reg <= 9'h000;
    end else if (usTick) begin
      usTick_reg <= 9'h000;
    end else begin
      usTick_reg <= usTick_reg + 9'h001;
    end
  end
  assign usTick = (usTick_reg == US_CYCLES - 1);

  // Reload on warm-down trigger; zero setting kills it at once
  always @* begin
    extCount_next = extCount_reg;
    if (extendUs_reg == 8'h00) begin
      extCount_next = 8'h00;
    end else if (seqWarmDownStart && seqRequest) begin
      extCount_next = extendUs_reg;
    end else if (usTick && extCount_reg != 8'h00) begin
      extCount_next = extCount_reg - 8'h01;
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      extCount_reg <= 8'h00;
    end else begin
      extCount_reg <= extCount_next;
    end
  end
  // Tick phase is not aligned to the trigger, so length is up to 1 us short
  assign extActive = (extCount_reg != 8'h00);

  // ****************************************************************
  // Coexistence source mux
  // ****************************************************************
  // OR hides the gap between back-to-back sequences
  assign coexReq = coext_reg[`RCC_F_COEXSEL] ? llRequest :
    (seqRequest | extActive);
  assign coexDir = coext_reg[`RCC_F_COEXSEL] ? llDirection : seqDirection;
  assign coexPri = coext_reg[`RCC_F_COEXSEL] ? llPriority :
    {1'b0, seqPriority};

  // ****************************************************************
  // Mode controller request
  // ****************************************************************
  // Wake-up delay in 32 kHz cycles after XO enable
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wakeCount_reg <= 6'h00;
      wakeReq_reg <= 1'b0;
      xoSeen_reg <= 1'b0;
    end else begin
      xoSeen_reg <= xoEnable;
      if (lowPowerRequest || !lpcEnabled) begin
        wakeReq_reg <= 1'b0;
        wakeCount_reg <= 6'h00;
      end else if (xoEnable && !xoSeen_reg) begin
        wakeCount_reg <= wakeDelay;
        wakeReq_reg <= (wakeDelay == 6'h00);
      end else if (refEdge && wakeCount_reg != 6'h00) begin
        wakeCount_reg <= wakeCount_reg - 6'h01;
        if (wakeCount_reg == 6'h01) begin
          wakeReq_reg <= 1'b1;
        end
      end
    end
  end

  assign modeReq = coext_reg[`RCC_F_FORCE] |
    (lpcEnabled & (idleTrack ? seqBusy : wakeReq_reg));

  // Source select for the request output
  always @* begin
    case (srcSel)
      `RCC_SRC_MODE: reqNext = modeReq;
      `RCC_SRC_SEQLL: reqNext = coexReq;
      `RCC_SRC_CLKREQ: reqNext = bleClockRequest;
      default: reqNext = 1'b0;
    endcase
  end

  // ****************************************************************
  // Outputs and request flag
  // ****************************************************************
  // Registered outputs; flag set wins over same-cycle clear
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      radioRequestOut <= 1'b0;
      radioDirectionOut <= 1'b0;
      radioPriorityOut <= 2'h0;
      radioStop <= 1'b0;
      quietSystemReq <= 1'b0;
      quietRadioReq <= 1'b0;
      modeCtrlOutputMux <= 8'h00;
      prevReq_reg <= 1'b0;
      assertedFlag_reg <= 1'b0;
      requestIrq <= 1'b0;
    end else begin
      radioRequestOut <= reqNext;
      prevReq_reg <= reqNext;
      radioDirectionOut <= coext_reg[`RCC_F_DIRSW] ?
        coext_reg[`RCC_F_DIRVAL] : coexDir;
      radioPriorityOut <= coexPri;
      radioStop <= denyLevel;
      // Quiet source: request output or sequencer busy
      quietSystemReq <= coext_reg[`RCC_F_QSOC] &
        (coext_reg[`RCC_F_QSRC] ? seqBusy : reqNext);
      quietRadioReq <= coext_reg[`RCC_F_QRF] &
        (coext_reg[`RCC_F_QSRC] ? seqBusy : reqNext);
      modeCtrlOutputMux <= {3'h0, denyLevel, coexPri,
        coext_reg[`RCC_F_DIRSW] ? coext_reg[`RCC_F_DIRVAL] : coexDir, reqNext};
      if (reqNext && !prevReq_reg) begin
        assertedFlag_reg <= 1'b1;
      end else if (regWrite && regAddr == `RCC_ADDR_FLAGS && regWdata[0]) begin
        assertedFlag_reg <= 1'b0;
      end
      requestIrq <= coext_reg[`RCC_F_IE] &
        (assertedFlag_reg | (reqNext & ~prevReq_reg));
    end
  end
  // Antenna confirm is software-only via a GPIO, so no port here

endmodule
`default_nettype wire

// ==== rcc_coexist_chk.sv ====
// Checker for the coexistence control ports
`timescale 1ns/100ps
`default_nettype none
module rcc_coexist_chk #(
  parameter DENY_PINS = 5
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [3:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [31:0] regRdata,
  input wire logic seqRequest,
  input wire logic [1:0] llPriority,
  input wire logic bleClockRequest,
  input wire logic [DENY_PINS-1:0] denyPins,
  input wire logic radioRequestOut,
  input wire logic radioDirectionOut,
  input wire logic [1:0] radioPriorityOut,
  input wire logic radioStop,
  input wire logic requestIrq
);
  logic [31:0] coextReg;
  logic [7:0] extReg;
  // Decoded views of the shadow words
  wire seqMode = coextReg[1:0] == 2'h1 && !coextReg[5];
  wire seqOff = seqMode && extReg == 8'h0 && !seqRequest;
  wire [2:0] denySel = coextReg[10:8];
  wire denyHit = denySel != 3'h0 && denySel <= 3'h5 && denyPins[denySel - 3'h1];
  // ****
  // Shadow of what software wrote, so outputs are judged on intent
  // ****
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      coextReg <= 32'h0;
      extReg <= 8'h0;
    end else if (regWrite && regAddr == 4'h1) begin
      coextReg <= regWdata;
    end else if (regWrite && regAddr == 4'h0) begin
      extReg <= regWdata[7:0];
    end
  end
  default clocking @(posedge clk);
  endclocking
  default disable iff (!nrst);
  // Config held steady one cycle before judging, as writes land a cycle late
  AST_EXT_READ: assert property (regRead && regAddr == 4'h0 |=> regRdata == {24'h0, extReg})
    else $error("ext read");
  AST_SEQ_REQ: assert property (seqMode && $stable(coextReg) && seqRequest |=> radioRequestOut)
    else $error("seq req");
  AST_EXT_OFF: assert property (seqOff && $stable(coextReg) && $stable(extReg) |=> !radioRequestOut)
    else $error("ext off");
  AST_CLK_REQ: assert property (coextReg[1:0] == 2'h2 && $stable(coextReg) |=> radioRequestOut == $past(bleClockRequest))
    else $error("clk req");
  AST_DIR_SW: assert property (coextReg[6] && $stable(coextReg) |=> radioDirectionOut == $past(coextReg[7]))
    else $error("dir sw");
  AST_PRI_LL: assert property (coextReg[5] && $stable(coextReg) |=> radioPriorityOut == $past(llPriority))
    else $error("ll pri");
  AST_PRI_SEQ: assert property (!coextReg[5] && $stable(coextReg) |=> !radioPriorityOut[1])
    else $error("seq pri");
  AST_IRQ: assert property ($rose(radioRequestOut) && coextReg[4] |-> ##[1:3] requestIrq)
    else $error("irq");
  AST_DENY_ON: assert property (denyHit [*4] |-> radioStop)
    else $error("deny on");
  AST_DENY_OFF: assert property ((denySel == 3'h0) [*4] |-> !radioStop)
    else $error("deny off");
endmodule
bind rcc_coexist_control rcc_coexist_chk #(.DENY_PINS(DENY_PINS)) rcc_coexist_chk_i (.*);
`default_nettype wire

// ==== rcc_wifi_peer.sv ====
// Behavioural co-located wireless peer on the deny pins
`timescale 1ns/100ps
`default_nettype none
module rcc_wifi_peer #(
  parameter int PIN = 2,
  parameter int HOLD = 40
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic radioRequestOut,
  input wire logic wantAir,
  output logic [4:0] denyPins
);
  int holdCnt;
  logic spin;
  // ****
  // Grant kept for the hold time after our request drops
  // ****
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      holdCnt <= 0;
      spin <= 1'b0;
    end else begin
      spin <= !spin;
      if (radioRequestOut) holdCnt <= HOLD;
      else if (holdCnt > 0) holdCnt <= holdCnt - 1;
    end
  end
  // Unused pins toggle so a wrong pin pick cannot pass by luck
  always @* begin
    denyPins = {5{spin}};
    denyPins[PIN] = wantAir && !radioRequestOut && holdCnt == 0;
  end
endmodule
`default_nettype wire

// ==== rcc_coexist_control_tb.sv ====
// Self-checking bench for the coexistence control block
`timescale 1ns/100ps
`default_nettype none
module rcc_coexist_control_tb;
  logic clk, nrst, regWrite, regRead, seqRequest, seqDirection, seqPriority, seqBusy, seqWarmDownStart;
  logic llRequest, llDirection, bleClockRequest, lpcEnabled, xoEnable, lowPowerRequest, refClk32k;
  logic wantAir, radioRequestOut, radioDirectionOut, radioStop, quietSystemReq, quietRadioReq, requestIrq;
  logic [1:0] llPriority, radioPriorityOut;
  logic [3:0] regAddr;
  logic [31:0] regWdata, regRdata, rv;
  logic [4:0] denyPins;
  logic [7:0] modeCtrlOutputMux;
  logic [20:0] rows [10];
  int fails, totalChecks, n;
  // Short microsecond so extension lengths stay cheap
  rcc_coexist_control #(.US_CYCLES(4)) rcc_coexist_control_i (.*);
  rcc_wifi_peer #(.PIN(2), .HOLD(40)) rcc_wifi_peer_i (.*);
  // ****
  // Clocks and helpers
  // ****
  initial begin
    clk = 1'b0;
    forever #2 clk = !clk;
  end
  // Reference sped up to 40 cycles a period to keep wake-up short
  initial begin
    refClk32k = 1'b0;
    forever #80 refClk32k = !refClk32k;
  end
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    totalChecks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    tick(1);
    regWrite <= 1'b0;
    // Idle edge so a following write never re-raises the strobe in this step
    tick(1);
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    regAddr <= a;
    regRead <= 1'b1;
    tick(1);
    regRead <= 1'b0;
    tick(1);
    d = regRdata;
  endtask
  // One sequence ending at the first warm-down step
  task automatic fire;
    {seqRequest, seqWarmDownStart} <= 2'h3;
    tick(1);
    {seqRequest, seqWarmDownStart} <= 2'h0;
    tick(1);
  endtask
  task automatic end_of_test;
    if (fails == 0 && totalChecks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    tick(5000);
    fails++;
    end_of_test;
  end
  // ****
  // Main sequence: table rows, then hand-written cases
  // ****
  initial begin
    {nrst, regWrite, regRead, seqRequest, seqDirection, seqPriority, seqBusy, seqWarmDownStart} <= '0;
    {llRequest, llDirection, llPriority, bleClockRequest, xoEnable, lowPowerRequest, wantAir} <= '0;
    {regAddr, regWdata} <= '0;
    lpcEnabled <= 1'b1;
    rows = '{{8'h01, 9'h1c0, 4'hd},
      {8'h21, 9'h02c, 4'hb},
      {8'h02, 9'h002, 4'h8},
      {8'h02, 9'h100, 4'h0},
      {8'h04, 9'h001, 4'h8},
      {8'h04, 9'h100, 4'h0},
      {8'h08, 9'h000, 4'h8},
      {8'hc1, 9'h000, 4'h4},
      {8'h41, 9'h080, 4'h0},
      {8'h03, 9'h102, 4'h0}};
    tick(20);
    nrst <= 1'b1;
    tick(2);
    wr(4'h0, 32'h1ff);
    rd(4'h0, rv);
    chk("extreg", 32'hff, rv);
    rd(4'h9, rv);
    chk("unmapped", 32'h0, rv);
    for (n = 0; n < 10; n++) begin
      wr(4'h1, {24'h0, rows[n][20:13]});
      {seqRequest, seqDirection, seqPriority, llRequest, llDirection, llPriority, bleClockRequest, seqBusy} <= rows[n][12:4];
      tick(3);
      chk("row", {28'h0, rows[n][3:0]}, {28'h0, radioRequestOut, radioDirectionOut, radioPriorityOut});
      chk("mux", {28'h0, rows[n][1:0], rows[n][2], rows[n][3]}, {28'h0, modeCtrlOutputMux[3:0]});
    end
    wr(4'h1, 32'h1);
    wr(4'h0, 32'h3);
    // Extension must repeat on each sequence, reloading every time
    repeat (2) begin
      fire;
      n = 0;
      while (radioRequestOut !== 1'b0 && n < 99) begin
        tick(1);
        n++;
      end
      chk("extlen", 32'h1, {31'h0, n >= 7 && n <= 14});
      tick(2);
    end
    wr(4'h0, 32'hff);
    fire;
    tick(5);
    // Status shows the running extension and the request it holds up
    rd(4'h3, rv);
    chk("status", 32'h3, {30'h0, rv[4:3]});
    wr(4'h0, 32'h0);
    tick(3);
    chk("extcut", 32'h0, {31'h0, radioRequestOut});
    fire;
    tick(2);
    chk("noext", 32'h0, {31'h0, radioRequestOut});
    wr(4'h1, 32'h3011);
    wr(4'h2, 32'h1);
    seqRequest <= 1'b1;
    tick(4);
    chk("irq", 32'h1, {31'h0, requestIrq});
    chk("quiet", 32'h1, {31'h0, quietSystemReq});
    chk("quietrf", 32'h1, {31'h0, quietRadioReq});
    rd(4'h2, rv);
    chk("flag", 32'h1, rv);
    seqRequest <= 1'b0;
    wr(4'h2, 32'h1);
    tick(2);
    chk("irqclr", 32'h0, {31'h0, requestIrq});
    wr(4'h1, 32'h300);
    wantAir <= 1'b1;
    tick(50);
    chk("deny", 32'h1, {31'h0, radioStop});
    chk("muxdeny", 32'h1, {31'h0, modeCtrlOutputMux[4]});
    wr(4'h1, 32'h0);
    tick(4);
    chk("denyoff", 32'h0, {31'h0, radioStop});
    wr(4'h1, 32'h20000);
    xoEnable <= 1'b1;
    tick(5);
    chk("wake", 32'h0, {31'h0, radioRequestOut});
    tick(120);
    chk("wake", 32'h1, {31'h0, radioRequestOut});
    lowPowerRequest <= 1'b1;
    tick(3);
    chk("sleep", 32'h0, {31'h0, radioRequestOut});
    wr(4'h1, 32'h20008);
    tick(3);
    chk("force", 32'h1, {31'h0, radioRequestOut});
    // Idle tracking with no low-power controller: request must stay low
    wr(4'h1, 32'h3804);
    lpcEnabled <= 1'b0;
    seqBusy <= 1'b1;
    tick(3);
    chk("nolpc", 32'h0, {31'h0, radioRequestOut});
    chk("quietbusy", 32'h1, {31'h0, quietRadioReq});
    lpcEnabled <= 1'b1;
    tick(3);
    chk("lpc", 32'h1, {31'h0, radioRequestOut});
    nrst <= 1'b0;
    tick(2);
    chk("reset", 32'h0, {26'h0, radioRequestOut, radioPriorityOut, radioStop, quietSystemReq, requestIrq});
    nrst <= 1'b1;
    tick(2);
    rd(4'h1, rv);
    chk("coext", 32'h0, rv);
    end_of_test;
  end
endmodule
`default_nettype wire
